// ---- pkg/clk_ctrl_pkg.sv ----
// Behaviour
// - power down waits for enable and wfi
// - stay powered down until wake-up, then leave
// - power down stops fast crystal and oscillator
// - five clock sources feed the generator
// - pll reference selects crystal or fast oscillator
// - system clock chosen by select a bits 2:0
// - tick timer uses cpu or external clock
// - external tick source from select a bits 5:3
// - each peripheral clock gated on its own
// - peripheral sources held in select b and c
// - power down stops system and fast clocks
// - slow oscillator and slow crystal keep running
// - rtc clock, and watchdog clock when sourced from lirc, survive power down
// - sixteen stage divider with sixteen way tap
// - output equals input over two power n+1
// - writing run enable one starts counter
// - after run cleared, stop once output low
// - wake-up clears power-down enable automatically
// - wake-up sets flag bit 6, write one clears
`default_nettype none
package clk_ctrl_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_POWER_DOWN_CONTROL = 8'h00;
  localparam logic [7:0] OFF_FAST_BUS_CLOCK_ENABLES = 8'h04;
  localparam logic [7:0] OFF_PERIPHERAL_BUS_CLOCK_ENABLES = 8'h08;
  localparam logic [7:0] OFF_CLOCK_STATUS_MONITOR = 8'h0C;
  localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT_A = 8'h10;
  localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT_B = 8'h14;
  localparam logic [7:0] OFF_CLOCK_DIVIDER_NUMBERS = 8'h18;
  localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT_C = 8'h1C;
  localparam logic [7:0] OFF_PLL_CONTROL = 8'h20;
  localparam logic [7:0] OFF_FREQUENCY_DIVIDER_CONTROL = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_POWER_DOWN_CONTROL = 32'h0000001F;
  localparam logic [31:0] RST_FAST_BUS_CLOCK_ENABLES = 32'h0000000D;
  localparam logic [31:0] RST_PERIPHERAL_BUS_CLOCK_ENABLES = 32'h00000001;
  localparam logic [31:0] RST_CLOCK_SOURCE_SELECT_A = 32'h0000003F;
  localparam logic [31:0] RST_CLOCK_SOURCE_SELECT_B = 32'hFFFFFFFF;
  localparam logic [31:0] RST_CLOCK_DIVIDER_NUMBERS = 32'h00000000;
  localparam logic [31:0] RST_CLOCK_SOURCE_SELECT_C = 32'h000000F0;
  localparam logic [31:0] RST_PLL_CONTROL = 32'h0005C22E;
  localparam logic [4:0] RST_FREQUENCY_DIVIDER_CONTROL = 5'h00;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PWR_HXT_EN = 0;
  localparam int PWR_LXT_EN = 1;
  localparam int PWR_HIRC_EN = 2;
  localparam int PWR_LIRC_EN = 3;
  localparam int PWR_WAKE_INT_EN = 5;
  localparam int PWR_WAKEUP_FLAG = 6;
  localparam int PWR_DOWN_ENABLE = 7;
  localparam logic [31:0] PWR_WRITE_MASK = 32'h000000BF;
  localparam int SEL_SYS_LSB = 0;
  localparam int SEL_TICK_LSB = 3;
  localparam int SEL_WDT_LSB = 0;
  localparam int SEL_FRQ_LSB = 2;
  localparam int PLL_REF_BIT = 19;
  localparam int APB_WDT_BIT = 0;
  localparam int APB_RTC_BIT = 1;
  localparam int FRQ_RUN_BIT = 4;
  localparam int IRQ_WAKEUP = 0;
  localparam int IRQ_ENTERED = 1;
  localparam int IRQ_DIV_STOP = 2;
  localparam int IRQ_BITS = 3;
  // ****************************************************************
  // clock sources and select codes
  // ****************************************************************
  localparam int NUM_SRC = 5;
  localparam int SRC_HXT = 0;
  localparam int SRC_LXT = 1;
  localparam int SRC_PLL = 2;
  localparam int SRC_LIRC = 3;
  localparam int SRC_HIRC = 4;
  localparam logic [2:0] CODE_HXT = 3'h0;
  localparam logic [2:0] CODE_LXT = 3'h1;
  localparam logic [2:0] CODE_PLL = 3'h2;
  localparam logic [2:0] CODE_LIRC = 3'h3;
  localparam logic [2:0] CODE_HIRC = 3'h7;
  localparam logic [1:0] WDT_FROM_LIRC = 2'h3;
  localparam logic [1:0] FRQ_FROM_HXT = 2'h0;
  localparam logic [1:0] FRQ_FROM_LXT = 2'h1;
  localparam logic [1:0] FRQ_FROM_SYS = 2'h2;
  localparam int DIV_STAGES = 16;
  localparam int DIV_TAP_W = 4;
  typedef enum logic [0:0] {PM_RUN, PM_DOWN} power_state_t;
endpackage : clk_ctrl_pkg
`default_nettype wire

// ---- rtl/clock_controller_power_down.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_controller_power_down (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt
  output logic irq,
  // raw clock sources, sampled as levels
  input wire logic crystal_hs_in,
  input wire logic crystal_32k_in,
  input wire logic pll_output_clock,
  input wire logic osc_10k_in,
  input wire logic osc_22m_in,
  // core handshake
  input wire logic cpu_wfi,
  input wire logic tick_use_cpu_clock,
  input wire logic wakeup_event,
  // source enables
  output logic crystal_hs_enable,
  output logic crystal_32k_enable,
  output logic osc_22m_enable,
  output logic osc_10k_enable,
  output logic pll_enable,
  output logic pll_reference_osc,
  // generated clocks
  output logic system_clock,
  output logic core_tick_clock,
  output logic divided_clock_output,
  output logic power_down_active,
  // peripheral clocking
  output logic [31:0] fast_bus_clock_en,
  output logic [31:0] periph_bus_clock_en,
  output logic [31:0] second_clock_source_select,
  output logic [31:0] third_clock_source_select,
  output logic [31:0] clock_divider_value
);
  import clk_ctrl_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int SYNC_W = NUM_SRC + 1;
  localparam int WAKE_IDX = NUM_SRC;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [NUM_SRC-1:0] live;
  logic frq_src_ff;
  logic frq_src_lvl;
  logic frq_rise;

  logic [31:0] pwr_ff;
  logic [31:0] fast_bus_clock_enables_ff;
  logic [31:0] peripheral_bus_clock_enables_ff;
  logic [31:0] sel_a_ff;
  logic [31:0] sel_b_ff;
  logic [31:0] div_ff;
  logic [31:0] sel_c_ff;
  logic [31:0] pll_ff;
  logic [4:0] frq_ff;
  logic [IRQ_BITS-1:0] irq_status_ff;
  logic [IRQ_BITS-1:0] irq_mask_ff;
  logic [IRQ_BITS-1:0] irq_events;

  power_state_t state_ff;
  logic enter_pd;
  logic leave_pd;
  logic div_stopped;
  logic div_out;

  logic addr_phase;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] rd_word;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic irq_ff;

  logic hxt_en_ff;
  logic lxt_en_ff;
  logic hirc_en_ff;
  logic lirc_en_ff;
  logic pll_en_ff;
  logic pll_ref_ff;
  logic sys_clk_ff;
  logic tick_clk_ff;
  logic [31:0] ahb_en_ff;
  logic [31:0] apb_en_ff;

  // ****************************************************************
  // source decode, shared by system and tick muxes
  // ****************************************************************
  function automatic logic pick_source(input logic [2:0] code, input logic [NUM_SRC-1:0] lv);
    logic r;
    r = 1'b0;
    case (code)
      CODE_HXT: r = lv[SRC_HXT];
      CODE_LXT: r = lv[SRC_LXT];
      CODE_PLL: r = lv[SRC_PLL];
      CODE_LIRC: r = lv[SRC_LIRC];
      default: r = lv[SRC_HIRC];
    endcase
    return r;
  endfunction : pick_source

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // sampling at hclk aliases sources faster than half its rate; the
  // outputs are a level model of the muxes, not glitch-free clocks
  assign raw_in[SRC_HXT] = crystal_hs_in;
  assign raw_in[SRC_LXT] = crystal_32k_in;
  assign raw_in[SRC_PLL] = pll_output_clock;
  assign raw_in[SRC_LIRC] = osc_10k_in;
  assign raw_in[SRC_HIRC] = osc_22m_in;
  assign raw_in[WAKE_IDX] = wakeup_event;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // the fast sources are dead while powered down; slow ones only follow their enables
  assign live[SRC_HXT] = sync2_ff[SRC_HXT] & hxt_en_ff;
  assign live[SRC_LXT] = sync2_ff[SRC_LXT] & lxt_en_ff;
  assign live[SRC_PLL] = sync2_ff[SRC_PLL] & pll_en_ff;
  assign live[SRC_LIRC] = sync2_ff[SRC_LIRC] & lirc_en_ff;
  assign live[SRC_HIRC] = sync2_ff[SRC_HIRC] & hirc_en_ff;

  // ****************************************************************
  // power-down sequencing
  // ****************************************************************
  assign enter_pd = (state_ff == PM_RUN) && pwr_ff[PWR_DOWN_ENABLE] && cpu_wfi;
  assign leave_pd = (state_ff == PM_DOWN) && sync2_ff[WAKE_IDX];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= PM_RUN;
    end else begin
      unique case (state_ff)
        PM_RUN: begin
          if (enter_pd) begin
            state_ff <= PM_DOWN;
          end
        end
        PM_DOWN: begin
          if (leave_pd) begin
            state_ff <= PM_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // ahb-lite slave: writes zero wait, reads one wait state
  // ****************************************************************
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      rd_pend_ff <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

  // the wait state lets hrdata, registered in the first data phase cycle, load on the same edge that hreadyout rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else if (addr_phase && !hwrite) begin
      hreadyout_ff <= 1'b0;
    end else if (rd_pend_ff) begin
      hreadyout_ff <= 1'b1;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (addr_ff)
      OFF_POWER_DOWN_CONTROL: rd_word = pwr_ff;
      OFF_FAST_BUS_CLOCK_ENABLES: rd_word = fast_bus_clock_enables_ff;
      OFF_PERIPHERAL_BUS_CLOCK_ENABLES: rd_word = peripheral_bus_clock_enables_ff;
      OFF_CLOCK_STATUS_MONITOR: rd_word = {26'h0000000, (state_ff == PM_DOWN),
                                           hirc_en_ff, lirc_en_ff, pll_en_ff,
                                           lxt_en_ff, hxt_en_ff};
      OFF_CLOCK_SOURCE_SELECT_A: rd_word = sel_a_ff;
      OFF_CLOCK_SOURCE_SELECT_B: rd_word = sel_b_ff;
      OFF_CLOCK_DIVIDER_NUMBERS: rd_word = div_ff;
      OFF_CLOCK_SOURCE_SELECT_C: rd_word = sel_c_ff;
      OFF_PLL_CONTROL: rd_word = pll_ff;
      OFF_FREQUENCY_DIVIDER_CONTROL: rd_word = {27'h0000000, frq_ff};
      OFF_IRQ_STATUS: rd_word = {{(32-IRQ_BITS){1'b0}}, irq_status_ff};
      OFF_IRQ_MASK: rd_word = {{(32-IRQ_BITS){1'b0}}, irq_mask_ff};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= rd_word;
    end
  end

  // ****************************************************************
  // power control register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_ff <= RST_POWER_DOWN_CONTROL;
    end else begin
      if (wr_pend_ff && addr_ff == OFF_POWER_DOWN_CONTROL) begin
        pwr_ff <= (hwdata & PWR_WRITE_MASK) | (pwr_ff & ~PWR_WRITE_MASK);
        if (hwdata[PWR_WAKEUP_FLAG]) begin
          pwr_ff[PWR_WAKEUP_FLAG] <= 1'b0;
        end
      end
      // hardware wins over a same-cycle software write
      if (leave_pd) begin
        pwr_ff[PWR_DOWN_ENABLE] <= 1'b0;
        pwr_ff[PWR_WAKEUP_FLAG] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // clock enable, select and divider registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_bus_clock_enables_ff <= RST_FAST_BUS_CLOCK_ENABLES;
      peripheral_bus_clock_enables_ff <= RST_PERIPHERAL_BUS_CLOCK_ENABLES;
      sel_a_ff <= RST_CLOCK_SOURCE_SELECT_A;
      sel_b_ff <= RST_CLOCK_SOURCE_SELECT_B;
      div_ff <= RST_CLOCK_DIVIDER_NUMBERS;
      sel_c_ff <= RST_CLOCK_SOURCE_SELECT_C;
      pll_ff <= RST_PLL_CONTROL;
      frq_ff <= RST_FREQUENCY_DIVIDER_CONTROL;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        OFF_FAST_BUS_CLOCK_ENABLES: fast_bus_clock_enables_ff <= hwdata;
        OFF_PERIPHERAL_BUS_CLOCK_ENABLES: peripheral_bus_clock_enables_ff <= hwdata;
        OFF_CLOCK_SOURCE_SELECT_A: sel_a_ff <= hwdata;
        OFF_CLOCK_SOURCE_SELECT_B: sel_b_ff <= hwdata;
        OFF_CLOCK_DIVIDER_NUMBERS: div_ff <= hwdata;
        OFF_CLOCK_SOURCE_SELECT_C: sel_c_ff <= hwdata;
        OFF_PLL_CONTROL: pll_ff <= hwdata;
        OFF_FREQUENCY_DIVIDER_CONTROL: frq_ff <= hwdata[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  assign irq_events[IRQ_WAKEUP] = leave_pd && pwr_ff[PWR_WAKE_INT_EN];
  assign irq_events[IRQ_ENTERED] = enter_pd;
  assign irq_events[IRQ_DIV_STOP] = div_stopped;

  // a read clears the status; an event in that same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= '0;
    end else if (rd_pend_ff && addr_ff == OFF_IRQ_STATUS) begin
      irq_status_ff <= irq_events;
    end else begin
      irq_status_ff <= irq_status_ff | irq_events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_ff <= '0;
    end else if (wr_pend_ff && addr_ff == OFF_IRQ_MASK) begin
      irq_mask_ff <= hwdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ****************************************************************
  // source enables and peripheral gating
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hxt_en_ff <= 1'b0;
      lxt_en_ff <= 1'b0;
      hirc_en_ff <= 1'b0;
      lirc_en_ff <= 1'b0;
      pll_en_ff <= 1'b0;
      pll_ref_ff <= 1'b0;
      ahb_en_ff <= 32'h00000000;
      apb_en_ff <= 32'h00000000;
    end else begin
      hxt_en_ff <= pwr_ff[PWR_HXT_EN] && (state_ff == PM_RUN);
      hirc_en_ff <= pwr_ff[PWR_HIRC_EN] && (state_ff == PM_RUN);
      lxt_en_ff <= pwr_ff[PWR_LXT_EN];
      lirc_en_ff <= pwr_ff[PWR_LIRC_EN];
      pll_en_ff <= (state_ff == PM_RUN);
      pll_ref_ff <= pll_ff[PLL_REF_BIT];
      ahb_en_ff <= (state_ff == PM_RUN) ? fast_bus_clock_enables_ff : 32'h00000000;
      if (state_ff == PM_RUN) begin
        apb_en_ff <= peripheral_bus_clock_enables_ff;
      end else begin
        apb_en_ff <= 32'h00000000;
        apb_en_ff[APB_WDT_BIT] <= peripheral_bus_clock_enables_ff[APB_WDT_BIT] &&
            (sel_b_ff[SEL_WDT_LSB +: 2] == WDT_FROM_LIRC);
        apb_en_ff[APB_RTC_BIT] <= peripheral_bus_clock_enables_ff[APB_RTC_BIT];
      end
    end
  end

  // ****************************************************************
  // system, tick and divider source muxes
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_clk_ff <= 1'b0;
      tick_clk_ff <= 1'b0;
    end else if (state_ff == PM_DOWN) begin
      sys_clk_ff <= 1'b0;
      tick_clk_ff <= 1'b0;
    end else begin
      sys_clk_ff <= pick_source(sel_a_ff[SEL_SYS_LSB +: 3], live);
      tick_clk_ff <= tick_use_cpu_clock ? pick_source(sel_a_ff[SEL_SYS_LSB +: 3], live)
                                        : pick_source(sel_a_ff[SEL_TICK_LSB +: 3], live);
    end
  end

  always_comb begin
    frq_src_lvl = live[SRC_HIRC];
    case (sel_c_ff[SEL_FRQ_LSB +: 2])
      FRQ_FROM_HXT: frq_src_lvl = live[SRC_HXT];
      FRQ_FROM_LXT: frq_src_lvl = live[SRC_LXT];
      FRQ_FROM_SYS: frq_src_lvl = sys_clk_ff;
      default: frq_src_lvl = live[SRC_HIRC];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frq_src_ff <= 1'b0;
    end else begin
      frq_src_ff <= frq_src_lvl;
    end
  end

  assign frq_rise = frq_src_lvl && !frq_src_ff;

  freq_divider #(
    .STAGES(DIV_STAGES),
    .TAP_W(DIV_TAP_W)
  ) u_divider (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_rise(frq_rise),
    .run_enable(frq_ff[FRQ_RUN_BIT]),
    .tap_select(frq_ff[DIV_TAP_W-1:0]),
    .divided_out(div_out),
    .stopped_pulse(div_stopped)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign irq = irq_ff;
  assign crystal_hs_enable = hxt_en_ff;
  assign crystal_32k_enable = lxt_en_ff;
  assign osc_22m_enable = hirc_en_ff;
  assign osc_10k_enable = lirc_en_ff;
  assign pll_enable = pll_en_ff;
  assign pll_reference_osc = pll_ref_ff;
  assign system_clock = sys_clk_ff;
  assign core_tick_clock = tick_clk_ff;
  assign divided_clock_output = div_out;
  assign power_down_active = (state_ff == PM_DOWN);
  assign fast_bus_clock_en = ahb_en_ff;
  assign periph_bus_clock_en = apb_en_ff;
  assign second_clock_source_select = sel_b_ff;
  assign third_clock_source_select = sel_c_ff;
  assign clock_divider_value = div_ff;
endmodule : clock_controller_power_down
`default_nettype wire

// ---- rtl/freq_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module freq_divider #(
  parameter int STAGES = clk_ctrl_pkg::DIV_STAGES,
  parameter int TAP_W = clk_ctrl_pkg::DIV_TAP_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic src_rise,
  input wire logic run_enable,
  input wire logic [TAP_W-1:0] tap_select,
  // result
  output logic divided_out,
  output logic stopped_pulse
);
  import clk_ctrl_pkg::*;

  generate
    if ((2 ** TAP_W) != STAGES) begin : g_bad_size
      $error("freq_divider: tap select width must address every stage");
    end
  endgenerate

  logic [STAGES-1:0] chain_ff;
  logic out_ff;
  logic stop_ff;
  logic run_ff;
  logic active;
  logic [STAGES-1:0] nxt_chain;

  // counter keeps running while enabled, or until the tap falls low
  assign active = run_enable | out_ff;
  assign nxt_chain = (src_rise && active) ? chain_ff + {{(STAGES-1){1'b0}}, 1'b1} : chain_ff;

  // ****************************************************************
  // chained divide-by-two stages
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= nxt_chain;
    end
  end

  // bit n of a binary count toggles every 2^n input rises, a period of 2^(n+1) input cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= active ? nxt_chain[tap_select] : 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      // pulse when the counter halts, even if the tap was already low
      run_ff <= active;
      stop_ff <= run_ff && !active;
    end
  end

  assign divided_out = out_ff;
  assign stopped_pulse = stop_ff;
endmodule : freq_divider
`default_nettype wire

// ---- tb/clock_controller_power_down_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_controller_power_down_props (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // power
  input wire logic cpu_wfi,
  input wire logic wakeup_event,
  input wire logic power_down_active,
  input wire logic crystal_hs_enable,
  input wire logic osc_22m_enable,
  input wire logic crystal_32k_enable,
  input wire logic osc_10k_enable,
  input wire logic pll_enable,
  input wire logic system_clock
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // *****
  // checks
  // *****
  a_entry_needs_wfi: assert property ($rose(power_down_active) |-> $past(cpu_wfi))
    else $error("entry without wfi");
  a_exit_on_wake: assert property ($fell(power_down_active) |->
    $past(wakeup_event, 2) || $past(wakeup_event, 3) || $past(wakeup_event, 4))
    else $error("exit without wake-up");
  // enables are registered, so they lag the state by one cycle
  a_fast_src_off: assert property (power_down_active && $past(power_down_active) |->
    !crystal_hs_enable && !osc_22m_enable && !pll_enable) else $error("fast source on");
  a_sys_clock_off: assert property (power_down_active && $past(power_down_active) |->
    !system_clock) else $error("system clock runs");
  a_slow_src_kept: assert property ($rose(power_down_active) |=>
    $stable(crystal_32k_enable) && $stable(osc_10k_enable)) else $error("slow source changed");
  a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_always_okay: assert property (!hresp) else $error("error response");
  c_enter: cover property ($rose(power_down_active));
  c_leave: cover property ($fell(power_down_active));
  c_read: cover property (hsel && hready && htrans[1] && !hwrite);
endmodule : clock_controller_power_down_props
bind clock_controller_power_down clock_controller_power_down_props u_props (.*);
`default_nettype wire

// ---- tb/test_clock_controller_power_down.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_clock_controller_power_down;
  // *****
  // signals
  // *****
  logic hclk, hresetn, hsel, hwrite, cpu_wfi, wakeup_event, hs_run;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, fbe, pbe;
  logic [4:0] src, cnt;
  logic [2:0] hsize = 3'h2;
  logic tick_use_cpu_clock = 1'b0;
  logic hready, hreadyout, hresp, irq, crystal_hs_enable, crystal_32k_enable;
  logic osc_22m_enable, osc_10k_enable, pll_enable, pll_reference_osc, system_clock;
  logic core_tick_clock, divided_clock_output, power_down_active;
  int num_errors, checks_done;
  assign hready = hreadyout;
  clock_controller_power_down DUT (.*, .crystal_hs_in(src[0]), .crystal_32k_in(src[1]),
    .pll_output_clock(src[2]), .osc_10k_in(src[3]), .osc_22m_in(src[4]),
    .fast_bus_clock_en(fbe), .periph_bus_clock_en(pbe), .second_clock_source_select(),
    .third_clock_source_select(), .clock_divider_value());
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // crystal at a quarter of hclk so every sampled edge is clean
  always @(posedge hclk) begin
    cnt <= cnt + 5'h01;
    if (hs_run && cnt[0]) src[0] <= ~src[0];
  end
  // *****
  // helpers
  // *****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // hready and hrdata are read at the rising edge, before the design updates them
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
        num_errors++;
        stop_test();
      end
      r = hrdata;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdc
  task automatic look(input logic [1:0] exp);
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk({system_clock, core_tick_clock}, exp);
  endtask : look
  task automatic per(input int exp);
    int t[3];
    int k;
    logic last;
    k = 0;
    last = 1'b1;
    for (int n = 0; n < 300 && k < 3; n++) begin
      @(negedge hclk);
      if (divided_clock_output && !last) begin
        t[k] = n;
        k++;
      end
      last = divided_clock_output;
    end
    chk(t[2] - t[1], exp);
  endtask : per
  // *****
  // scenarios
  // *****
  task automatic t_regs;
    rdc(8'h04, 32'h0000000D);
    rdc(8'h14, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0005C22E);
    rdc(8'h24, 32'h00000000);
    wr(8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'h00000000);
    wr(8'h18, 32'hA5C30F96);
    rdc(8'h18, 32'hA5C30F96);
    $display("register test done");
  endtask : t_regs
  task automatic t_select;
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, {26'h0, (i == 4) ? 6'h3F : {2{3'(i)}}});
      src <= 5'h01 << i;
      look(2'h3);
      src <= 5'h00;
      look(2'h0);
    end
    wr(8'h10, 32'h1);
    src <= 5'h02;
    look(2'h2);
    tick_use_cpu_clock <= 1'b1;
    look(2'h3);
    tick_use_cpu_clock <= 1'b0;
    wr(8'h20, 32'h000DC22E);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(pll_reference_osc, 1'b1);
    $display("select test done");
  endtask : t_select
  task automatic t_power;
    int n;
    wr(8'h2C, 32'h4);
    wr(8'h00, 32'hAF);
    repeat (4) @(negedge hclk);
    chk(power_down_active, 1'b0);
    @(posedge hclk);
    cpu_wfi <= 1'b1;
    @(posedge hclk);
    cpu_wfi <= 1'b0;
    repeat (12) @(negedge hclk);
    chk({power_down_active, crystal_hs_enable, osc_22m_enable, crystal_32k_enable,
      osc_10k_enable}, 5'h13);
    chk({fbe[3:0], pbe[3:0]}, 8'h01);
    @(posedge hclk);
    wakeup_event <= 1'b1;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (power_down_active !== 1'b0 && n < 20);
    chk(power_down_active, 1'b0);
    @(posedge hclk);
    wakeup_event <= 1'b0;
    rdc(8'h00, 32'h6F);
    chk(irq, 1'b0);
    wr(8'h2C, 32'h7);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b1);
    rdc(8'h28, 32'h3);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    wr(8'h00, 32'h4F);
    rdc(8'h00, 32'h0F);
    $display("power test done");
  endtask : t_power
  task automatic t_div;
    logic hi;
    hs_run <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(8'h24, {27'h0, 1'b1, 4'(k)});
      per(8 << k);
    end
    wr(8'h24, 32'h1);
    repeat (20) @(posedge hclk);
    hi = 1'b0;
    repeat (40) begin
      @(negedge hclk);
      hi = hi | divided_clock_output;
    end
    chk(hi, 1'b0);
    rdc(8'h28, 32'h4);
    hs_run <= 1'b0;
    $display("divider test done");
  endtask : t_div
  initial begin
    {hresetn, hsel, hwrite, cpu_wfi, wakeup_event, hs_run} = 6'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    src = 5'h00;
    cnt = 5'h00;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_select();
    t_power();
    t_div();
    stop_test();
  end
endmodule : test_clock_controller_power_down
`default_nettype wire
